// File: logic/odc_top.sv
// Octal 10-bit converter control: serial command port, latch logic, registers.
// Assumes serial pins come from another domain; AXI4-Lite master on ref_clk.
`timescale 1ns/10ps
`default_nettype none
module odc_top #(
  parameter int NUM_CH = 8,
  parameter int CODE_W = 10
) (
  input  wire logic                 ref_clk,
  input  wire logic                 reset_n,
  input  wire logic                 serial_clk,
  input  wire logic                 serial_data,
  input  wire logic                 select_n,
  input  wire logic                 load_strobe_n,
  input  wire odc_pkg::odc_axi_req_t axi_req,
  output var  odc_pkg::odc_axi_rsp_t axi_rsp,
  output var  odc_pkg::odc_grp_t     group_cfg,
  output var  logic [7:0][9:0]       chan_level
);
  // ==========================================================================
  // Elaboration checks
  if (NUM_CH != odc_pkg::ODC_NUM_CH || CODE_W != odc_pkg::ODC_CODE_W)
  begin : g_bad_size
    $error("odc_top serves eight channels of ten bits only");
  end

  odc_pkg::odc_state_t st;
  odc_pkg::odc_state_t nx;
  logic        sck_rise;
  logic        sel_rise;
  logic        sel_fall;
  logic        strobe_fall;
  logic        word_done;
  logic        int_pulse;
  logic        xfer;
  logic        sleep_bad;
  logic [31:0] rd;
  logic        rd_ok;
  logic [15:0] w;
  logic [2:0]  sub;

  // ==========================================================================
  // Next state
  always_comb
  begin
    nx          = st;
    sck_rise    = 1'b0;
    sel_rise    = 1'b0;
    sel_fall    = 1'b0;
    strobe_fall = 1'b0;
    word_done   = 1'b0;
    int_pulse   = 1'b0;
    xfer        = 1'b0;
    sleep_bad   = 1'b0;
    rd          = 32'h0000_0000;
    rd_ok       = 1'b0;
    w           = st.shift;
    sub         = st.shift[odc_pkg::ODC_POS_SEL +: 3];
    // Pin synchronisers; only stages two and three are compared
    // Stages reset to the idle pin level, so no false edge follows reset
    nx.sck_s = {st.sck_s[1:0], serial_clk};
    nx.sdi_s = {st.sdi_s[1:0], serial_data};
    nx.sel_s = {st.sel_s[1:0], select_n};
    nx.ld_s  = {st.ld_s[1:0], load_strobe_n};
    if (st.sck_s[2] == st.sck_s[1])
    begin
      sck_rise = st.sck_s[2] && !st.sck_h;
      nx.sck_h = st.sck_s[2];
    end
    if (st.sel_s[2] == st.sel_s[1])
    begin
      sel_rise = st.sel_s[2] && !st.sel_h;
      sel_fall = !st.sel_s[2] && st.sel_h;
      nx.sel_h = st.sel_s[2];
    end
    if (st.ld_s[2] == st.ld_s[1])
    begin
      strobe_fall = !st.ld_s[2] && st.ld_h && (st.mode == odc_pkg::ODC_MODE_HOLD);
      nx.ld_h = st.ld_s[2];
    end
    // Serial shifter, MSB first inside the select frame
    if (sel_fall)
    begin
      nx.cnt = 5'h00;
    end
    else if (sck_rise && !st.sel_h)
    begin
      nx.shift = {st.shift[14:0], st.sdi_s[2]};
      if (st.cnt != 5'h1F)
      begin
        nx.cnt = st.cnt + 5'h01;
      end
    end
    // A short or long frame is dropped whole rather than half applied
    word_done = sel_rise && st.ser_en && (st.cnt == odc_pkg::ODC_WORD_BITS);
    if (word_done)
    begin
      if (!w[odc_pkg::ODC_POS_KIND])
      begin
        nx.in_code[sub] = w[odc_pkg::ODC_POS_CODE +: 10];
        nx.dirty[sub]   = 1'b1;
        nx.awake        = 1'b1;
      end
      else
      begin
        case (sub)
          odc_pkg::ODC_SUB_CONFIG:
          begin
            nx.ref_sup = w[odc_pkg::ODC_POS_REF +: 2];
            nx.buf_en  = w[odc_pkg::ODC_POS_BUF +: 2];
            nx.gain2   = w[odc_pkg::ODC_POS_GAIN +: 2];
            nx.awake   = 1'b1;
          end
          odc_pkg::ODC_SUB_LATCH_MODE_WRITE:
          begin
            // Code 11 is not a mode; the word is ignored
            if (w[1:0] != 2'h3)
            begin
              nx.mode   = w[1:0];
              int_pulse = (w[1:0] == odc_pkg::ODC_MODE_PULSE);
              nx.awake  = 1'b1;
            end
          end
          odc_pkg::ODC_SUB_CHANNEL_SLEEP:
          begin
            nx.sleep = w[7:0];
            nx.awake = 1'b1;
          end
          odc_pkg::ODC_SUB_CLEAR_CODES:
          begin
            nx.in_code  = '0;
            nx.out_code = '0;
            nx.dirty    = '0;
            nx.awake    = 1'b1;
          end
          odc_pkg::ODC_SUB_FULL_CLEAR:
          begin
            nx.in_code  = '0;
            nx.out_code = '0;
            nx.dirty    = '0;
            nx.sleep    = '0;
            nx.ref_sup  = odc_pkg::ODC_ST_RST.ref_sup;
            nx.buf_en   = odc_pkg::ODC_ST_RST.buf_en;
            nx.gain2    = odc_pkg::ODC_ST_RST.gain2;
            nx.mode     = odc_pkg::ODC_ST_RST.mode;
            nx.awake    = 1'b1;
          end
          default:
          begin
            nx.awake = st.awake;
          end
        endcase
      end
    end
    // Transfer only channels whose input changed since their last load
    xfer = (nx.mode == odc_pkg::ODC_MODE_CONT) || strobe_fall || int_pulse;
    for (int i = 0; i < 8; i++)
    begin
      if (xfer && nx.dirty[i])
      begin
        nx.out_code[i] = nx.in_code[i];
        nx.dirty[i]    = 1'b0;
      end
      nx.level[i] = (nx.awake && !nx.sleep[i]) ? nx.out_code[i] : 10'h000;
      sleep_bad   = sleep_bad || (st.sleep[i] && (st.level[i] != 10'h000));
    end
    // Supply reference overrides buffer and gain; analogue scaling is off-chip
    nx.grp.supply_rail_sel = nx.ref_sup;
    nx.grp.buf_on  = nx.buf_en & ~nx.ref_sup;
    nx.grp.gain_x2 = nx.gain2 & ~nx.ref_sup;

    // ========================================================================
    // AXI4-Lite write channel
    if (axi_req.awvalid && st.axi.awready)
    begin
      nx.aw_got  = 1'b1;
      nx.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && st.axi.wready)
    begin
      nx.w_got = 1'b1;
      nx.wdata = axi_req.wdata;
      nx.wstrb = axi_req.wstrb;
    end
    if (st.aw_got && st.w_got && !st.axi.bvalid)
    begin
      nx.aw_got     = 1'b0;
      nx.w_got      = 1'b0;
      nx.axi.bvalid = 1'b1;
      nx.axi.bresp  = odc_pkg::ODC_RESP_SLVERR;
      if (st.aw_addr[7:2] == odc_pkg::ODC_OFS_CTRL[7:2])
      begin
        nx.axi.bresp = odc_pkg::ODC_RESP_OKAY;
        if (st.wstrb[0])
        begin
          nx.ser_en = st.wdata[0];
        end
      end
    end
    if (st.axi.bvalid && axi_req.bready)
    begin
      nx.axi.bvalid = 1'b0;
    end
    nx.axi.awready = !nx.aw_got && !nx.axi.bvalid;
    nx.axi.wready  = !nx.w_got && !nx.axi.bvalid;
    // ========================================================================
    // AXI4-Lite read channel
    if (axi_req.araddr[7:2] == odc_pkg::ODC_OFS_CTRL[7:2])
    begin
      rd    = {31'h0000_0000, st.ser_en};
      rd_ok = 1'b1;
    end
    else if (axi_req.araddr[7:2] == odc_pkg::ODC_OFS_STATUS[7:2])
    begin
      rd    = {st.dirty, 7'h00, st.awake, st.sleep, st.gain2, st.buf_en, st.ref_sup, st.mode};
      rd_ok = 1'b1;
    end
    for (int i = 0; i < 8; i++)
    begin
      if (axi_req.araddr[7:2] == odc_pkg::ODC_OFS_LEVEL0[7:2] + 6'(i))
      begin
        rd    = {6'h00, st.in_code[i], 6'h00, st.level[i]};
        rd_ok = 1'b1;
      end
    end
    if (axi_req.arvalid && st.axi.arready)
    begin
      nx.axi.rvalid = 1'b1;
      nx.axi.rdata  = rd;
      nx.axi.rresp  = rd_ok ? odc_pkg::ODC_RESP_OKAY : odc_pkg::ODC_RESP_SLVERR;
    end
    else if (st.axi.rvalid && axi_req.rready)
    begin
      nx.axi.rvalid = 1'b0;
    end
    nx.axi.arready = !nx.axi.rvalid;
  end

  // ==========================================================================
  // State register
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      st <= odc_pkg::ODC_ST_RST;
    end
    else
    begin
      st <= nx;
    end
  end

  assign axi_rsp    = st.axi;
  assign group_cfg  = st.grp;
  assign chan_level = st.level;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_pulse_mode_word;
    word_done && st.shift[15:12] == {1'b1, odc_pkg::ODC_SUB_LATCH_MODE_WRITE}
      && st.shift[1:0] == odc_pkg::ODC_MODE_PULSE;
  endsequence
  sequence s_sub_word(logic [2:0] code);
    word_done && st.shift[15] && st.shift[14:12] == code;
  endsequence
  sequence s_hold_chan_write;
    word_done && !st.shift[15] && st.mode == odc_pkg::ODC_MODE_HOLD && !strobe_fall;
  endsequence

  AST_POWER_ON_ZERO: assert property (!st.awake |-> chan_level == '0)
    else $error("output nonzero before first write");
  AST_SLEEP_ZERO: assert property (!sleep_bad)
    else $error("sleeping channel shows a nonzero level");
  AST_SUPPLY_UNITY: assert property (((group_cfg.buf_on | group_cfg.gain_x2)
    & group_cfg.supply_rail_sel) == 2'h0)
    else $error("supply reference with buffer or gain active");
  AST_HOLD_STABLE: assert property (st.mode == odc_pkg::ODC_MODE_HOLD && !strobe_fall
    && !word_done |=> $stable(st.out_code))
    else $error("output changed in hold mode without a strobe");
  AST_STROBE_LOAD: assert property (strobe_fall && !word_done |=> st.dirty == 8'h00
    ##0 st.out_code == st.in_code)
    else $error("strobe did not load changed inputs");
  AST_CONTINUOUS: assert property (st.mode == odc_pkg::ODC_MODE_CONT |->
    st.out_code == st.in_code)
    else $error("continuous mode output lags input");
  AST_PULSE_LOAD: assert property (s_pulse_mode_word |=> st.dirty == 8'h00
    ##0 st.mode == odc_pkg::ODC_MODE_PULSE)
    else $error("internal load pulse missing");
  AST_CLEAR_CODES: assert property (s_sub_word(odc_pkg::ODC_SUB_CLEAR_CODES) |=>
    st.in_code == '0 ##0 $stable(st.mode) ##0 $stable(st.ref_sup))
    else $error("clear codes wrong");
  AST_FULL_CLEAR: assert property (s_sub_word(odc_pkg::ODC_SUB_FULL_CLEAR) |=>
    st.in_code == '0 && st.mode == odc_pkg::ODC_MODE_HOLD && st.ref_sup == 2'h0)
    else $error("full clear did not restore defaults");
  AST_CHAN_WRITE: assert property (s_hold_chan_write |=> $stable(st.out_code)
    && st.dirty[$past(st.shift[14:12])])
    else $error("channel write reached the output early");
  AST_AXI_READ: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid
    ##1 (axi_rsp.rvalid || axi_rsp.arready))
    else $error("read answer missing");
  // Refused words, sleep mask, full clear and the write answer
  AST_SER_OFF: assert property (sel_rise && !st.ser_en |=> $stable(st.in_code)
    ##0 $stable(st.mode))
    else $error("word acted while the serial port was disabled");
  AST_LATCH_REFUSE: assert property (word_done && st.shift[1:0] == 2'h3
    && st.shift[15:12] == {1'b1, odc_pkg::ODC_SUB_LATCH_MODE_WRITE} |=> $stable(st.mode))
    else $error("latch code 11 changed the mode");
  AST_SLEEP_WRITE: assert property (s_sub_word(odc_pkg::ODC_SUB_CHANNEL_SLEEP) |=>
    st.sleep == $past(st.shift[7:0]))
    else $error("sleep mask not taken");
  AST_FULL_WAKE: assert property (s_sub_word(odc_pkg::ODC_SUB_FULL_CLEAR) |=>
    st.sleep == 8'h00 ##0 st.buf_en == 2'h0 ##0 st.gain2 == 2'h0)
    else $error("full clear left sleep, buffer or gain set");
  AST_AXI_WRITE: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid
    && axi_rsp.wready |=> !axi_rsp.awready ##1 axi_rsp.bvalid)
    else $error("write answer missing");
endmodule
`default_nettype wire

// File: logic/odc_pkg.sv
// Shared constants and carrier types for the octal converter control block.
// Assumes a 10 MHz ref_clk and an AXI4-Lite master on the register side.
`default_nettype none
package odc_pkg;
  // ==========================================================================
  // Sizes
  localparam int ODC_NUM_CH   = 8;
  localparam int ODC_CODE_W   = 10;
  localparam int ODC_WORD_W   = 16;
  localparam logic [4:0] ODC_WORD_BITS = 5'h10;
  // ==========================================================================
  // Serial word layout
  localparam int ODC_POS_KIND = 15;
  localparam int ODC_POS_SEL  = 12;
  localparam int ODC_POS_CODE = 2;
  localparam int ODC_POS_REF  = 0;
  localparam int ODC_POS_BUF  = 2;
  localparam int ODC_POS_GAIN = 4;
  localparam logic [2:0] ODC_SUB_CONFIG             = 3'h0;
  localparam logic [2:0] ODC_SUB_LATCH_MODE_WRITE   = 3'h1;
  localparam logic [2:0] ODC_SUB_CHANNEL_SLEEP      = 3'h2;
  localparam logic [2:0] ODC_SUB_CLEAR_CODES        = 3'h3;
  localparam logic [2:0] ODC_SUB_FULL_CLEAR         = 3'h4;
  // ==========================================================================
  // Latch modes
  localparam logic [1:0] ODC_MODE_CONT  = 2'h0;
  localparam logic [1:0] ODC_MODE_HOLD  = 2'h1;
  localparam logic [1:0] ODC_MODE_PULSE = 2'h2;
  // ==========================================================================
  // Register map, byte addresses
  localparam logic [7:0] ODC_OFS_CTRL   = 8'h00;
  localparam logic [7:0] ODC_OFS_STATUS = 8'h04;
  localparam logic [7:0] ODC_OFS_LEVEL0 = 8'h08;
  localparam logic [1:0] ODC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] ODC_RESP_SLVERR = 2'h2;
  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } odc_axi_req_t;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } odc_axi_rsp_t;
  typedef struct packed {
    logic [1:0] supply_rail_sel;
    logic [1:0] buf_on;
    logic [1:0] gain_x2;
  } odc_grp_t;
  typedef struct packed {
    logic [2:0]  sck_s;
    logic [2:0]  sdi_s;
    logic [2:0]  sel_s;
    logic [2:0]  ld_s;
    logic        sck_h;
    logic        sel_h;
    logic        ld_h;
    logic [15:0] shift;
    logic [4:0]  cnt;
    logic [7:0][9:0] in_code;
    logic [7:0][9:0] out_code;
    logic [7:0][9:0] level;
    logic [7:0]  dirty;
    logic [7:0]  sleep;
    logic [1:0]  ref_sup;
    logic [1:0]  buf_en;
    logic [1:0]  gain2;
    logic [1:0]  mode;
    logic        awake;
    logic        ser_en;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  aw_addr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    odc_grp_t    grp;
    odc_axi_rsp_t axi;
  } odc_state_t;
  // ==========================================================================
  // Values after reset
  localparam odc_state_t ODC_ST_RST = '{
    sel_s: 3'h7, ld_s: 3'h7,
    sel_h: 1'b1, ld_h: 1'b1, mode: ODC_MODE_HOLD, ser_en: 1'b1,
    axi: '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0},
    default: '0};
endpackage
`default_nettype wire

// File: bench/odc_ser_ctl.sv
// Far-side serial controller model that drives the command and load pins.
// Assumes ref_clk from the bench; the bench calls its tasks.
`timescale 1ns/10ps
`default_nettype none
module odc_ser_ctl (
  input  wire logic ref_clk,
  output var  logic serial_clk,
  output var  logic serial_data,
  output var  logic select_n,
  output var  logic load_strobe_n
);
  // ==========================================
  // Idle levels
  initial
  begin
    serial_clk    = 1'b0;
    serial_data   = 1'b0;
    select_n      = 1'b1;
    load_strobe_n = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // ==========================================
  // One frame; hold is cycles per clock level, 4 or more
  task automatic send(input logic [15:0] w, input int nb, input int hold);
    int i;
    @(posedge ref_clk);
    select_n <= 1'b0;
    for (i = 15; i > 15 - nb; i--)
    begin
      serial_data <= w[i];
      serial_clk  <= 1'b0;
      tick(hold);
      serial_clk <= 1'b1;
      tick(hold);
    end
    select_n    <= 1'b1;
    serial_clk  <= 1'b0;
    // Released line must not keep showing the last bit
    serial_data <= ~serial_data;
    tick(hold);
  endtask
  task automatic strobe(input int hold);
    @(posedge ref_clk);
    load_strobe_n <= 1'b0;
    tick(hold);
    load_strobe_n <= 1'b1;
    tick(hold);
  endtask
endmodule
`default_nettype wire

// File: bench/octal_dac_control_tb.sv
// Self-checking bench for odc_top against an integer model of the converter.
// Assumes odc_pkg, odc_top and the serial model odc_ser_ctl.
`timescale 1ns/10ps
`default_nettype none
module octal_dac_control_tb;
  logic                  ref_clk = 1'b0;
  logic                  reset_n = 1'b0;
  wire                   serial_clk;
  wire                   serial_data;
  wire                   select_n;
  wire                   load_strobe_n;
  odc_pkg::odc_axi_req_t axi_req = '0;
  odc_pkg::odc_axi_rsp_t axi_rsp;
  odc_pkg::odc_grp_t     group_cfg;
  logic [7:0][9:0]       chan_level;
  logic [9:0]            m_in [8];
  logic [9:0]            m_out [8];
  logic [7:0]            m_sleep = 8'h00;
  logic [1:0]            m_mode = 2'h1;
  logic [1:0]            m_ref = 2'h0;
  logic [1:0]            m_buf = 2'h0;
  logic [1:0]            m_gain = 2'h0;
  logic                  m_awake = 1'b0;
  logic                  m_en = 1'b1;
  logic [31:0]           seed = 32'h0000_003D;
  logic [11:0]           cfgs [3] = '{12'h03D, 12'h032, 12'h003};
  logic [31:0]           d;
  logic [1:0]            r;
  int                    n_fail = 0;
  int                    n_tests = 0;
  int                    hold = 4;
  int                    i;
  always #50 ref_clk = ~ref_clk;
  odc_top dut (
    .ref_clk       (ref_clk),
    .reset_n       (reset_n),
    .serial_clk    (serial_clk),
    .serial_data   (serial_data),
    .select_n      (select_n),
    .load_strobe_n (load_strobe_n),
    .axi_req       (axi_req),
    .axi_rsp       (axi_rsp),
    .group_cfg     (group_cfg),
    .chan_level    (chan_level)
  );
  odc_ser_ctl ctl (
    .ref_clk       (ref_clk),
    .serial_clk    (serial_clk),
    .serial_data   (serial_data),
    .select_n      (select_n),
    .load_strobe_n (load_strobe_n)
  );
  // ==========================================
  // Helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] cw(input int ch, input logic [31:0] c);
    return {1'b0, 3'(ch), c[9:0], 2'h0};
  endfunction
  function automatic logic [15:0] sw(input logic [2:0] s, input logic [11:0] p);
    return {1'b1, s, p};
  endfunction
  task automatic results();
    if (n_fail == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Outputs settle 4 cycles after the pin event; 12 leaves margin
  task automatic check_all();
    odc_pkg::odc_grp_t e;
    int k;
    repeat (12) @(posedge ref_clk);
    for (k = 0; k < 8; k++)
      chk("chan_level", (m_awake && !m_sleep[k]) ? 32'(m_out[k]) : '0, 32'(chan_level[k]));
    e.supply_rail_sel = m_ref;
    e.buf_on = m_buf & ~m_ref;
    e.gain_x2 = m_gain & ~m_ref;
    chk("group_cfg", 32'(e), 32'(group_cfg));
  endtask
  // ==========================================
  // Serial commands with model update
  task automatic cmd(input logic [15:0] w, input int nb);
    hold = 4 + int'(xs() % 32'h0000_0003);
    ctl.send(w, nb, hold);
    if (nb == 16 && m_en)
    begin
      m_awake = m_awake | (w[15:12] < 4'hD && w != sw(3'h1, 12'h003));
      if (!w[15])
        m_in[w[14:12]] = w[11:2];
      case (w[15:12])
        4'h8: {m_gain, m_buf, m_ref} = w[5:0];
        4'h9: if (w[1:0] != 2'h3) m_mode = w[1:0];
        4'hA: m_sleep = w[7:0];
        4'hB, 4'hC:
        begin
          m_in = '{default: 10'h000};
          m_out = '{default: 10'h000};
        end
        default: ;
      endcase
      if (w[15:12] == 4'hC)
        {m_mode, m_ref, m_buf, m_gain, m_sleep} = {2'h1, 14'h0000};
      if (m_mode == 2'h0 || w == sw(3'h1, 12'h002))
        m_out = m_in;
    end
    check_all();
  endtask
  task automatic pulse();
    ctl.strobe(hold);
    if (m_mode == 2'h1)
      m_out = m_in;
    check_all();
  endtask
  // ==========================================
  // AXI4-Lite master
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int k;
    @(posedge ref_clk);
    axi_req.awaddr <= a;
    axi_req.awvalid <= 1'b1;
    axi_req.wdata <= v;
    axi_req.wstrb <= 4'hF;
    axi_req.wvalid <= 1'b1;
    axi_req.bready <= 1'b1;
    for (k = 0; k < 100; k++)
    begin
      @(posedge ref_clk);
      if (axi_req.awvalid && axi_rsp.awready)
        axi_req.awvalid <= 1'b0;
      if (axi_req.wvalid && axi_rsp.wready)
        axi_req.wvalid <= 1'b0;
      if (axi_rsp.bvalid)
        break;
    end
    rs = axi_rsp.bresp;
    axi_req.bready <= 1'b0;
    if (k == 100)
    begin
      chk("axi_wait", 32'h0000_0000, 32'h0000_0001);
      results();
    end
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int k;
    @(posedge ref_clk);
    axi_req.araddr <= a;
    axi_req.arvalid <= 1'b1;
    axi_req.rready <= 1'b1;
    for (k = 0; k < 100; k++)
    begin
      @(posedge ref_clk);
      if (axi_req.arvalid && axi_rsp.arready)
        axi_req.arvalid <= 1'b0;
      if (axi_rsp.rvalid)
        break;
    end
    v = axi_rsp.rdata;
    rs = axi_rsp.rresp;
    axi_req.rready <= 1'b0;
    if (k == 100)
    begin
      chk("axi_wait", 32'h0000_0000, 32'h0000_0001);
      results();
    end
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    m_in = '{default: 10'h000};
    m_out = '{default: 10'h000};
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    check_all();
    axi_rd(odc_pkg::ODC_OFS_CTRL, d, r);
    chk("ctrl", 32'h0000_0001, d);
    chk("rresp", 32'(odc_pkg::ODC_RESP_OKAY), 32'(r));
    axi_rd(odc_pkg::ODC_OFS_STATUS, d, r);
    chk("mode", 32'h0000_0001, 32'(d[1:0]));
    chk("awake", 32'h0000_0000, 32'(d[16]));
    cmd(sw(odc_pkg::ODC_SUB_LATCH_MODE_WRITE, 12'h003), 16);
    for (i = 0; i < 3; i++)
      cmd(sw(odc_pkg::ODC_SUB_CONFIG, cfgs[i]), 16);
    for (i = 0; i < 8; i++)
      cmd(cw(i, xs()), 16);
    pulse();
    cmd(sw(odc_pkg::ODC_SUB_LATCH_MODE_WRITE, 12'h000), 16);
    cmd(cw(3, xs()), 16);
    cmd(sw(odc_pkg::ODC_SUB_LATCH_MODE_WRITE, 12'h001), 16);
    cmd(cw(5, xs()), 16);
    cmd(cw(6, xs()), 16);
    cmd(sw(odc_pkg::ODC_SUB_LATCH_MODE_WRITE, 12'h002), 16);
    cmd(cw(0, xs()), 16);
    pulse();
    cmd(cw(1, xs()), 15);
    cmd(sw(3'h5, 12'h0FF), 16);
    cmd(sw(odc_pkg::ODC_SUB_CHANNEL_SLEEP, 12'h0A5), 16);
    for (i = 0; i < 8; i++)
    begin
      axi_rd(odc_pkg::ODC_OFS_LEVEL0 + 8'(4 * i), d, r);
      chk("level_reg", m_sleep[i] ? '0 : 32'(m_out[i]), 32'(d[9:0]));
      chk("input_reg", 32'(m_in[i]), 32'(d[25:16]));
    end
    cmd(sw(odc_pkg::ODC_SUB_CHANNEL_SLEEP, 12'h000), 16);
    cmd(sw(odc_pkg::ODC_SUB_CLEAR_CODES, 12'h000), 16);
    cmd(cw(2, xs()), 16);
    cmd(sw(odc_pkg::ODC_SUB_FULL_CLEAR, 12'h000), 16);
    axi_rd(odc_pkg::ODC_OFS_STATUS, d, r);
    chk("mode", 32'h0000_0001, 32'(d[1:0]));
    axi_wr(odc_pkg::ODC_OFS_CTRL, 32'h0000_0000, r);
    chk("bresp", 32'(odc_pkg::ODC_RESP_OKAY), 32'(r));
    m_en = 1'b0;
    cmd(cw(4, xs()), 16);
    axi_wr(odc_pkg::ODC_OFS_CTRL, 32'h0000_0001, r);
    m_en = 1'b1;
    axi_rd(odc_pkg::ODC_OFS_CTRL, d, r);
    chk("ctrl", 32'h0000_0001, d);
    axi_wr(odc_pkg::ODC_OFS_STATUS, 32'hFFFF_FFFF, r);
    chk("bresp", 32'(odc_pkg::ODC_RESP_SLVERR), 32'(r));
    axi_rd(8'hFC, d, r);
    chk("rdata", 32'h0000_0000, d);
    chk("rresp", 32'(odc_pkg::ODC_RESP_SLVERR), 32'(r));
    results();
  end
endmodule
`default_nettype wire
